// *** pkg/adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_CTRL_ONE = 10'h001;
  localparam logic [9:0] IDX_STATUS = 10'h002;
  localparam logic [9:0] IDX_CMP_VALUE = 10'h004;
  localparam logic [9:0] IDX_RESULT = 10'h005;
  localparam logic [9:0] IDX_PWM_CTRL = 10'h006;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h007;
  localparam logic [9:0] IDX_IRQ_ENABLE = 10'h008;
  localparam logic [9:0] IDX_IRQ_CLEAR = 10'h009;
  localparam logic [9:0] IDX_CTRL_TWO = 10'h0e2;
  localparam logic [9:0] IDX_DELAY_LOW = 10'h0e3;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CT2_FBE_BIT = 7;
  localparam int CT2_POL_BIT = 6;
  localparam int CT2_GATE_BIT = 5;
  localparam int CT2_CMPO_BIT = 4;
  localparam int CT2_AQT_LSB = 1;
  localparam int CT2_DLY8_BIT = 0;
  localparam int CT1_DIV_LSB = 4;
  localparam int CT1_EXT_BIT = 1;
  localparam int CT1_EN_BIT = 0;
  localparam int STAT_DONE_BIT = 7;
  localparam int STAT_BUSY_BIT = 6;
  localparam int PWM_RUN_BIT = 7;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_BRAKE_BIT = 1;

  // ----------------------------------------------------------------
  // widths, reset values, timing
  // ----------------------------------------------------------------
  localparam int RESULT_W = 12;
  localparam int DELAY_W = 9;
  localparam int SAMP_W = 6;
  localparam int IRQ_W = 2;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] DELAY_LOW_RST = 8'h00;
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [11:0] CMP_VALUE_RST = 12'h000;
  localparam logic [SAMP_W-1:0] ACQ_BASE_CYCLES = 6'h06;
  localparam logic [1:0] DIV_BY_EIGHT = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_SAMPLE = 2'b10,
    ST_CONVERT = 2'b11
  } conv_state_e;

  // sampling length in converter clock cycles: 4 * field + 6
  function automatic logic [SAMP_W-1:0] acq_cycles(input logic [2:0] aqt);
    acq_cycles = {1'b0, aqt, 2'b00} + ACQ_BASE_CYCLES;
  endfunction

  // comparator: polarity 0 gives result >= value, 1 gives result < value
  function automatic logic cmp_match(input logic [RESULT_W-1:0] res,
                                     input logic [RESULT_W-1:0] val,
                                     input logic pol);
    cmp_match = pol ? (res < val) : (res >= val);
  endfunction

endpackage

// *** core/adc_clk_div.sv ***
`timescale 1ns/1ps
module adc_clk_div (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // divider select, 0..3 gives /1 /2 /4 /8
  input wire logic [1:0] div_sel_in,
  // one-cycle enable at the converter clock rate
  output logic tick_out
);
  import adc_ctrl_pkg::*;

  logic [2:0] count_q;
  logic tick_q;
  wire [2:0] limit = 3'((4'h1 << div_sel_in) - 4'h1);
  wire at_limit = (count_q >= limit);

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      count_q <= 3'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      count_q <= at_limit ? 3'h0 : 3'(count_q + 3'h1);
      tick_q <= at_limit;
    end
  end

  assign tick_out = tick_q;

  // a divider change in mid-period releases the check for that cycle
  a_div_rate: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (tick_q && div_sel_in == DIV_BY_EIGHT) |=>
    (!tick_q || div_sel_in != DIV_BY_EIGHT) [*7])
    else $error("divide by eight tick off period");

endmodule // adc_clk_div

// *** core/adc_compare_trigger_delay_ctrl.sv ***
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module adc_compare_trigger_delay_ctrl (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // external conversion trigger pin
  input wire logic ext_trigger_in,
  // analog converter core
  input wire logic conv_done_in,
  input wire logic [adc_ctrl_pkg::RESULT_W-1:0] conv_result_in,
  output logic adc_enable_out,
  output logic sample_out,
  output logic conv_start_out,
  // pwm unit
  output logic fault_brake_out,
  output logic pwm_run_out,
  // interrupt
  output logic irq_out
);
  import adc_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  conv_state_e state_q, state_d;
  logic [7:0] ctrl_two_q;
  logic [7:0] delay_low_q;
  logic [7:0] ctrl_one_q;
  logic [RESULT_W-1:0] cmp_value_q;
  logic [RESULT_W-1:0] result_q;
  logic cmpo_q;
  logic done_q;
  logic pwm_run_q;
  logic brake_q;
  logic [IRQ_W-1:0] irq_st_q, irq_en_q;
  logic irq_q;
  logic [DELAY_W-1:0] dly_cnt_q, dly_cnt_d;
  logic [SAMP_W-1:0] samp_cnt_q, samp_cnt_d;
  logic sample_q;
  logic conv_start_q, conv_start_d;
  logic ext_meta_q, ext_sync_q, ext_prev_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic adc_tick;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire [9:0] idx = paddr_in[11:2];
  wire aligned = (paddr_in[1:0] == 2'b00);
  wire setup = psel_in & ~penable_in;
  wire access = psel_in & penable_in & pready_q;
  wire wr = access & pwrite_in;
  wire hit_ct1 = aligned & (idx == IDX_CTRL_ONE);
  wire hit_stat = aligned & (idx == IDX_STATUS);
  wire hit_cmp = aligned & (idx == IDX_CMP_VALUE);
  wire hit_res = aligned & (idx == IDX_RESULT);
  wire hit_pwm = aligned & (idx == IDX_PWM_CTRL);
  wire hit_ist = aligned & (idx == IDX_IRQ_STATUS);
  wire hit_ien = aligned & (idx == IDX_IRQ_ENABLE);
  wire hit_icl = aligned & (idx == IDX_IRQ_CLEAR);
  wire hit_ct2 = aligned & (idx == IDX_CTRL_TWO);
  wire hit_dly = aligned & (idx == IDX_DELAY_LOW);
  wire mapped = hit_ct1 | hit_stat | hit_cmp | hit_res | hit_pwm | hit_ist
              | hit_ien | hit_icl | hit_ct2 | hit_dly;
  // read-only registers refuse writes with an error
  wire bad = ~mapped | (pwrite_in & (hit_res | hit_ist));

  wire [31:0] rd_mux =
      hit_ct1 ? {24'h000000, ctrl_one_q} :
      hit_stat ? {24'h000000, done_q, (state_q != ST_IDLE), 6'h00} :
      hit_cmp ? {20'h00000, cmp_value_q} :
      hit_res ? {20'h00000, result_q} :
      hit_pwm ? {24'h000000, pwm_run_q, 7'h00} :
      hit_ist ? {30'h00000000, irq_st_q} :
      hit_ien ? {30'h00000000, irq_en_q} :
      hit_ct2 ? {24'h000000, ctrl_two_q[7:5], cmpo_q, ctrl_two_q[3:0]} :
      hit_dly ? {24'h000000, delay_low_q} : 32'h00000000;

  wire wr_ct1 = wr & hit_ct1;
  wire wr_stat = wr & hit_stat;
  wire wr_cmp = wr & hit_cmp;
  wire wr_pwm = wr & hit_pwm;
  wire wr_ien = wr & hit_ien;
  wire wr_icl = wr & hit_icl;
  wire wr_ct2 = wr & hit_ct2;
  wire wr_dly = wr & hit_dly;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  wire adc_en = ctrl_one_q[CT1_EN_BIT];
  wire ext_en = ctrl_one_q[CT1_EXT_BIT];
  wire [1:0] div_sel = ctrl_one_q[CT1_DIV_LSB +: 2];
  wire fbe = ctrl_two_q[CT2_FBE_BIT];
  wire pol = ctrl_two_q[CT2_POL_BIT];
  wire gate = ctrl_two_q[CT2_GATE_BIT];
  wire [2:0] aqt = ctrl_two_q[CT2_AQT_LSB +: 3];
  wire [DELAY_W-1:0] delay_val = {ctrl_two_q[CT2_DLY8_BIT], delay_low_q};

  // ----------------------------------------------------------------
  // start, completion and compare events
  // ----------------------------------------------------------------
  wire ext_rise = ext_sync_q & ~ext_prev_q;
  wire sw_start = wr_stat & pwdata_in[STAT_BUSY_BIT];
  wire idle_ok = (state_q == ST_IDLE) & ~done_q & adc_en;
  wire ext_accept = idle_ok & ~sw_start & ext_en & ext_rise;
  wire sw_accept = idle_ok & sw_start;
  wire conv_evt = (state_q == ST_CONVERT) & conv_done_in;
  wire hit = cmp_match(conv_result_in, cmp_value_q, pol);
  wire set_done = conv_evt & (~gate | hit);
  wire restart = conv_evt & gate & ~hit;
  // only a fresh rise of the comparator trips the brake
  wire brake_evt = conv_evt & fbe & hit & ~cmpo_q;
  wire clr_done = wr_stat & ~pwdata_in[STAT_DONE_BIT];
  wire [IRQ_W-1:0] irq_evt = {brake_evt, set_done};

  adc_clk_div u_div (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .div_sel_in(div_sel),
    .tick_out(adc_tick)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    dly_cnt_d = dly_cnt_q;
    samp_cnt_d = samp_cnt_q;
    conv_start_d = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (sw_accept || (ext_accept && delay_val == '0))
        begin
          state_d = ST_SAMPLE;
          samp_cnt_d = acq_cycles(aqt);
        end
        else if (ext_accept)
        begin
          state_d = ST_DELAY;
          dly_cnt_d = delay_val;
        end
      end
      ST_DELAY:
      begin
        if (adc_tick)
        begin
          dly_cnt_d = DELAY_W'(dly_cnt_q - 1'b1);
          if (dly_cnt_q == 9'h001)
          begin
            state_d = ST_SAMPLE;
            samp_cnt_d = acq_cycles(aqt);
          end
        end
      end
      ST_SAMPLE:
      begin
        if (adc_tick)
        begin
          samp_cnt_d = SAMP_W'(samp_cnt_q - 1'b1);
          if (samp_cnt_q == 6'h01)
          begin
            state_d = ST_CONVERT;
            conv_start_d = 1'b1;
          end
        end
      end
      ST_CONVERT:
      begin
        if (restart)
        begin
          state_d = ST_SAMPLE;
          samp_cnt_d = acq_cycles(aqt);
        end
        else if (conv_evt)
        begin
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
    // turning the converter off abandons any conversion in flight
    if (!adc_en)
    begin
      state_d = ST_IDLE;
      conv_start_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      state_q <= ST_IDLE;
      dly_cnt_q <= '0;
      samp_cnt_q <= '0;
      sample_q <= 1'b0;
      conv_start_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      dly_cnt_q <= dly_cnt_d;
      samp_cnt_q <= samp_cnt_d;
      sample_q <= (state_d == ST_SAMPLE);
      conv_start_q <= conv_start_d;
    end
  end

  // ----------------------------------------------------------------
  // trigger synchroniser, results, flags
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
      result_q <= '0;
      cmpo_q <= 1'b0;
      done_q <= 1'b0;
      pwm_run_q <= 1'b0;
      brake_q <= 1'b0;
    end
    else
    begin
      ext_meta_q <= ext_trigger_in;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
      if (conv_evt)
      begin
        result_q <= conv_result_in;
        cmpo_q <= hit;
      end
      done_q <= set_done | (done_q & ~clr_done);
      // hardware brake wins over a simultaneous software set
      pwm_run_q <= ~brake_evt & (wr_pwm ? pwdata_in[PWM_RUN_BIT] : pwm_run_q);
      brake_q <= brake_evt | (brake_q & ~(wr_pwm & pwdata_in[PWM_RUN_BIT]));
    end
  end

  // ----------------------------------------------------------------
  // registers and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      ctrl_one_q <= CTRL_ONE_RST;
      ctrl_two_q <= CTRL_TWO_RST;
      delay_low_q <= DELAY_LOW_RST;
      cmp_value_q <= CMP_VALUE_RST;
      irq_en_q <= '0;
      irq_st_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      if (wr_ct1)
        ctrl_one_q <= pwdata_in[7:0];
      if (wr_ct2)
        ctrl_two_q <= pwdata_in[7:0] & ~(8'h01 << CT2_CMPO_BIT);
      if (wr_dly)
        delay_low_q <= pwdata_in[7:0];
      if (wr_cmp)
        cmp_value_q <= pwdata_in[RESULT_W-1:0];
      if (wr_ien)
        irq_en_q <= pwdata_in[IRQ_W-1:0];
      irq_st_q <= irq_evt | (irq_st_q & ~(wr_icl ? pwdata_in[IRQ_W-1:0] : 2'h0));
      irq_q <= |(irq_st_q & irq_en_q);
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup & bad;
      prdata_q <= (setup & ~pwrite_in) ? rd_mux : 32'h00000000;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign adc_enable_out = ctrl_one_q[CT1_EN_BIT];
  assign sample_out = sample_q;
  assign conv_start_out = conv_start_q;
  assign fault_brake_out = brake_q;
  assign pwm_run_out = pwm_run_q;
  assign irq_out = irq_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  a_brake_assert: assert property (brake_evt |=> brake_q && fault_brake_out)
    else $error("fault brake not asserted on compare");
  a_brake_run_clear: assert property (brake_evt |=> !pwm_run_out)
    else $error("run bit survived a compare brake");
  a_cmp_ge: assert property ((conv_evt && !pol) |=>
    cmpo_q == ($past(conv_result_in) >= $past(cmp_value_q)))
    else $error("polarity 0 compare wrong");
  a_cmp_lt: assert property ((conv_evt && pol) |=>
    cmpo_q == ($past(conv_result_in) < $past(cmp_value_q)))
    else $error("polarity 1 compare wrong");
  a_gate_no_flag: assert property ((conv_evt && gate && !hit && !done_q) |=>
    !done_q && state_q == ST_SAMPLE)
    else $error("gated miss set the flag or stopped");
  a_result_update: assert property (conv_evt |=> result_q == $past(conv_result_in))
    else $error("result not updated");
  a_cmpo_hold: assert property (!conv_evt |=> $stable(cmpo_q))
    else $error("compare output moved without a conversion");
  a_sample_load: assert property ($rose(sample_q) |-> samp_cnt_q == acq_cycles(aqt))
    else $error("sampling length wrong");
  a_delay_load: assert property ((ext_accept && delay_val != '0) |=>
    state_q == ST_DELAY && dly_cnt_q == $past(delay_val))
    else $error("delay not loaded from trigger");
  a_delay_zero: assert property ((ext_accept && delay_val == '0) |=> sample_q)
    else $error("zero delay did not sample at once");
  a_delay_wait: assert property ((state_q == ST_DELAY && dly_cnt_q > 9'h001) |=>
    !sample_q && !conv_start_q)
    else $error("conversion started before delay ran out");
  a_done_blocks: assert property ((done_q && state_q == ST_IDLE) |=>
    state_q == ST_IDLE && !conv_start_q)
    else $error("start while done flag set");

  c_gated_restart: cover property (restart ##[1:200] set_done);
  c_ext_delayed: cover property (ext_accept ##1 state_q == ST_DELAY ##[1:600] conv_start_q);
  c_brake: cover property (brake_evt ##[1:20] (wr_pwm && pwdata_in[PWM_RUN_BIT]));
  c_irq: cover property (set_done ##[1:4] irq_out);

endmodule // adc_compare_trigger_delay_ctrl

// *** test/adc_core_model.sv ***
`timescale 1ns/1ps
module adc_core_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control side
  input wire logic conv_start_in,
  input wire logic [11:0] next_result_in,
  input wire logic [3:0] latency_in,
  // result side
  output logic conv_done_out,
  output logic [11:0] conv_result_out
);
  int cnt;
  logic [11:0] last_q;
  // result lines change outside the done pulse, so a late sample shows up
  always @(posedge clk_in)
  begin
    conv_done_out <= 1'b0;
    conv_result_out <= ~last_q;
    if (rst_in)
    begin
      cnt <= 0;
      last_q <= 12'h000;
    end
    else if (conv_start_in)
      cnt <= latency_in + 1;
    else if (cnt == 1)
    begin
      conv_done_out <= 1'b1;
      conv_result_out <= next_result_in;
      last_q <= next_result_in;
      cnt <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule // adc_core_model

// *** test/adc_compare_trigger_delay_ctrl_test.sv ***
`timescale 1ns/1ps
module adc_compare_trigger_delay_ctrl_test;
  import adc_ctrl_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, trig = 1'b0;
  logic [11:0] paddr = 12'h000, nxt = 12'h000, result;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, done, sample, start, brake, run, irq, adc_en;
  logic [3:0] lat = 4'h2;
  int n_fail = 0, compares = 0, n_conv = 0, seed = 32'h4f86;
  logic [11:0] res_q[$];

  always #25 clk = ~clk;

  adc_compare_trigger_delay_ctrl u_dut (.core_clk_in(clk), .rst_in(rst), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .ext_trigger_in(trig),
    .conv_done_in(done), .conv_result_in(result), .adc_enable_out(adc_en),
    .sample_out(sample), .conv_start_out(start), .fault_brake_out(brake),
    .pwm_run_out(run), .irq_out(irq));

  adc_core_model u_core (.clk_in(clk), .rst_in(rst), .conv_start_in(start),
    .next_result_in(nxt), .latency_in(lat), .conv_done_out(done), .conv_result_out(result));

  // next result for repeated conversions
  always @(posedge clk)
    if (done === 1'b1)
    begin
      n_conv <= n_conv + 1;
      if (res_q.size() > 0)
        nxt <= res_q.pop_front();
    end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // idle edge first, so back-to-back calls never reassign psel in one step
  task automatic apb(input logic wr, input logic [9:0] i, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_fail++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rdc(input logic [9:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0);
    chk($sformatf("reg %h", i), rd, e);
  endtask

  // cycles until sampling starts and how long it lasts
  task automatic conv(output int g, output int w);
    g = 0;
    w = 0;
    while (sample !== 1'b1 && g < 2000)
    begin
      @(posedge clk);
      g++;
    end
    while (sample === 1'b1 && w < 2000)
    begin
      @(posedge clk);
      w++;
    end
    if (g >= 2000 || w >= 2000)
    begin
      n_fail++;
      tally_and_finish();
    end
    repeat (lat + 6) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int g, w, k, n, r, c, p, e, d;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdc(IDX_CTRL_TWO, 32'h0);
    rdc(IDX_DELAY_LOW, 32'h0);
    apb(1'b1, IDX_CTRL_TWO, 32'hff);
    rdc(IDX_CTRL_TWO, 32'hef);
    apb(1'b1, IDX_DELAY_LOW, 32'h1a5);
    rdc(IDX_DELAY_LOW, 32'ha5);
    apb(1'b0, 10'h3ff, 32'h0);
    chk("unmapped err", err, 1'b1);
    apb(1'b1, IDX_RESULT, 32'hfff);
    chk("ro write err", err, 1'b1);
    $display("test registers done");
    // aqt only changed while idle
    // aqt of 1 or more keeps sampling above 370 ns at /1
    for (k = 0; k < 4; k++)
    begin
      c = (k * 3 + 1) % 8;
      apb(1'b1, IDX_CTRL_ONE, (k << 4) | 1);
      apb(1'b1, IDX_CTRL_TWO, c << 1);
      apb(1'b1, IDX_STATUS, 32'h40);
      conv(g, w);
      e = (4 * c + 6) * (1 << k);
      chk("sample width", w >= e - (1 << k) + 1 && w <= e, 1'b1);
      rdc(IDX_STATUS, 32'h80);
      apb(1'b1, IDX_STATUS, 32'h40);
      // a refused start never samples, so watch a fixed span instead of waiting
      w = 0;
      repeat (40)
      begin
        @(posedge clk);
        w += (sample === 1'b1);
      end
      chk("start while done", w, 0);
      apb(1'b1, IDX_STATUS, 32'h0);
    end
    apb(1'b1, IDX_CTRL_ONE, 32'h1);
    chk("adc enable", adc_en, 1'b1);
    $display("test timing done");
    for (k = 0; k < 8; k++)
    begin
      r = $random(seed) & 12'hfff;
      c = (k == 0) ? r : $random(seed) & 12'hfff;
      p = k % 2;
      e = p ? (r < c) : (r >= c);
      nxt <= r;
      apb(1'b1, IDX_CMP_VALUE, c);
      apb(1'b1, IDX_CTRL_TWO, (p << 6) | 2);
      apb(1'b1, IDX_STATUS, 32'h40);
      conv(g, w);
      rdc(IDX_RESULT, r);
      rdc(IDX_CTRL_TWO, (p << 6) | (e << 4) | 2);
      apb(1'b1, IDX_STATUS, 32'h0);
    end
    rdc(IDX_IRQ_STATUS, 32'h1);
    apb(1'b1, IDX_IRQ_ENABLE, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq on", irq, 1'b1);
    apb(1'b1, IDX_IRQ_ENABLE, 32'h0);
    repeat (3) @(posedge clk);
    chk("irq masked", irq, 1'b0);
    apb(1'b1, IDX_IRQ_CLEAR, 32'h3);
    rdc(IDX_IRQ_STATUS, 32'h0);
    $display("test compare done");
    nxt <= 12'h100;
    res_q = '{12'h7ff, 12'h800};
    n = n_conv;
    apb(1'b1, IDX_CMP_VALUE, 32'h800);
    apb(1'b1, IDX_CTRL_TWO, 32'h22);
    apb(1'b1, IDX_STATUS, 32'h40);
    k = 0;
    do
    begin
      apb(1'b0, IDX_STATUS, 32'h0);
      k++;
    end
    while (rd[7] !== 1'b1 && k < 100);
    repeat (lat + 6) @(posedge clk);
    chk("gated count", n_conv - n, 3);
    rdc(IDX_RESULT, 32'h800);
    rdc(IDX_IRQ_STATUS, 32'h1);
    apb(1'b1, IDX_STATUS, 32'h0);
    $display("test gated done");
    apb(1'b1, IDX_PWM_CTRL, 32'h80);
    apb(1'b1, IDX_CMP_VALUE, 32'h400);
    apb(1'b1, IDX_CTRL_TWO, 32'h82);
    for (k = 0; k < 2; k++)
    begin
      nxt <= k ? 12'hfff : 12'h100;
      apb(1'b1, IDX_STATUS, 32'h40);
      conv(g, w);
      chk("brake", brake, k);
      chk("run", run, !k);
      apb(1'b1, IDX_STATUS, 32'h0);
    end
    rdc(IDX_IRQ_STATUS, 32'h3);
    apb(1'b1, IDX_PWM_CTRL, 32'h80);
    @(posedge clk);
    chk("run again", {brake, run}, 2'b01);
    $display("test brake done");
    apb(1'b1, IDX_CTRL_ONE, 32'h3);
    for (k = 0; k < 2; k++)
    begin
      d = k ? 0 : 12'h105;
      apb(1'b1, IDX_CTRL_TWO, (d >> 8) | 2);
      apb(1'b1, IDX_DELAY_LOW, d & 8'hff);
      trig <= 1'b1;
      conv(g, w);
      trig <= 1'b0;
      chk("trigger delay", g >= d + 2 && g <= d + 6, 1'b1);
      apb(1'b1, IDX_STATUS, 32'h0);
    end
    $display("test trigger done");
    tally_and_finish();
  end
endmodule // adc_compare_trigger_delay_ctrl_test
